//--- rtl/iae_cfg.svh
// constants for the interrupt arbiter and entry sequencer
`ifndef IAE_CFG_SVH
`define IAE_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IAE_OFS_CTRL        8'h00
`define IAE_OFS_EXT_EN      8'h04
`define IAE_OFS_PER_EN      8'h08
`define IAE_OFS_FLAGS       8'h0c
`define IAE_OFS_STATUS      8'h10
`define IAE_OFS_EXT_PEND    8'h14
`define IAE_OFS_PER_PEND    8'h18

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IAE_CTRL_EDGE_BIT   0
`define IAE_CTRL_EXTMEM_BIT 1
`define IAE_CTRL_WS_LSB     4
`define IAE_MASK_BIT        7
`define IAE_CTRL_RST        8'h00
`define IAE_FLAGS_RST       8'h80
`define IAE_EN_RST          32'h0000_0000

// ----------------------------------------------------------------
// vector numbers
// ----------------------------------------------------------------
`define IAE_VEC_NMI         6'h03
`define IAE_VEC_EXT_BASE    6'h04
`define IAE_VEC_PER_BASE    6'h0c

// ----------------------------------------------------------------
// state and word counts
// ----------------------------------------------------------------
`define IAE_PRIO_EXT_STATES 6'h02
`define IAE_PRIO_INT_STATES 6'h01
`define IAE_CHIP_WORD_STATES 6'h02
`define IAE_EXT_WORD_STATES 6'h06
`define IAE_INTERNAL_STATES 6'h04
`define IAE_FETCH_WORDS     2'h2

`endif

//--- rtl/iae_pkg.sv
// types shared by the interrupt arbiter and entry sequencer
`default_nettype none
package iae_pkg;

  typedef enum logic [2:0] {
    IAE_IDLE,
    IAE_PRIO,
    IAE_WAIT_END,
    IAE_PUSH_PC,
    IAE_PUSH_FLAGS,
    IAE_VECTOR,
    IAE_FETCH,
    IAE_INTERNAL
  } iae_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iae_mem_t;

endpackage

`default_nettype wire

//--- rtl/iae_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module iae_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta   <= INIT;
      sync_o <= INIT;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

//--- rtl/iae_interrupt_arbiter_and_entry.sv
// interrupt arbiter with hardware interrupt-entry sequencer and wishbone registers
`timescale 1ns/100ps
`default_nettype none
`include "iae_cfg.svh"

// Summary of operation
// R1: disabled maskable source never reaches arbiter
// R2: watchdog source has no enable bit
// R3: maskable accepted when enabled and mask clear
// R4: nonmaskable accepted unless reset or standby
// R5: mask set: only nonmaskable, others stay pending
// R6: present only highest priority vector to core
// R7: start entry at instruction end, latch vector
// R8: push counter first, then condition byte
// R9: set mask bit after stacking
// R10: load counter from vector table entry
// R11: condition byte stacked as doubled word
// R12: return restores flags from even byte
// R13: priority takes 2 states, internal 1
// R14: instruction completion wait 1-13 or 5-17
// R15: stack 4, vector 2, fetch 4, internal 4
// R16: wait states lengthen response accordingly
// R17: enable clear acts after clearing instruction
// R18: higher simultaneous request wins, disabled dropped
// R19: request flag clear deferred the same way
// R20: software clears enables only while masked
// R21: word accesses force address bit zero
// R22: nonmaskable uses vector 3
// R23: external lines vectors 4-11, line 0 first
// R24: internal sources vectors 12 to 44
// R25: edge select: 0 falling, 1 rising
// R26: vector address is twice vector number
module iae_interrupt_arbiter_and_entry
  import iae_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        standby_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        nonmask_n_i,
  input  wire logic [7:0]  ext_req_n_i,
  input  wire logic [32:0] periph_req_i,
  input  wire logic        instr_end_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [15:0] sp_i,
  input  wire logic        return_from_exception_op_i,
  input  wire logic [15:0] ret_word_i,
  input  wire logic [15:0] mem_rdata_i,
  output iae_mem_t         mem_o,
  output logic             int_req_o,
  output logic [5:0]       vector_o,
  output logic [7:0]       condition_flags_byte_o,
  output logic             entry_busy_o,
  output logic             branch_o,
  output logic [15:0]      branch_pc_o,
  output logic [15:0]      sp_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic       nmi_s;
  logic [7:0] ext_s;

  iae_sync2 #(.WIDTH(1), .INIT(1'b1)) u_sync_nmi (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (nonmask_n_i),
    .sync_o  (nmi_s)
  );

  iae_sync2 #(.WIDTH(8), .INIT(8'hff)) u_sync_ext (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (ext_req_n_i),
    .sync_o  (ext_s)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [7:0]  ext_en_sw;
  logic [31:0] per_en_sw;
  logic [7:0]  ext_en_eff;
  logic [31:0] per_en_eff;
  logic [32:0] per_pend;
  logic [7:0]  flags;
  logic        nmi_pend;
  logic        nmi_prev;
  iae_state_t  state;
  logic [5:0]  vec_lat;
  logic        wr_strobe;
  logic        set_mask;

  // writes land at the edge where the master samples ack high
  assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl      <= `IAE_CTRL_RST;
      ext_en_sw <= 8'(`IAE_EN_RST);
      per_en_sw <= `IAE_EN_RST;
    end else if (wr_strobe) begin
      case (wb_adr_i)
        `IAE_OFS_CTRL:   ctrl      <= 8'(lane_merge({24'h0, ctrl}, wb_dat_i, wb_sel_i));
        `IAE_OFS_EXT_EN: ext_en_sw <= 8'(lane_merge({24'h0, ext_en_sw}, wb_dat_i, wb_sel_i));
        `IAE_OFS_PER_EN: per_en_sw <= lane_merge(per_en_sw, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // new enables apply at once, clears only once the instruction ends
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_en_eff <= 8'(`IAE_EN_RST);
      per_en_eff <= `IAE_EN_RST;
    end else if (instr_end_i) begin
      ext_en_eff <= ext_en_sw; // see R17
      per_en_eff <= per_en_sw; // see R17
    end else begin
      ext_en_eff <= ext_en_eff | ext_en_sw;
      per_en_eff <= per_en_eff | per_en_sw;
    end
  end

  // peripheral flags: rises seen at once, falls deferred to instruction end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      per_pend <= 33'h0_0000_0000;
    end else if (instr_end_i) begin
      per_pend <= periph_req_i; // see R19
    end else begin
      per_pend <= per_pend | periph_req_i;
    end
  end

  // ----------------------------------------------------------------
  // nonmaskable edge detect
  // ----------------------------------------------------------------
  logic nmi_edge;
  logic nmi_take;

  assign nmi_edge = ctrl[`IAE_CTRL_EDGE_BIT] ? (~nmi_prev & nmi_s)
                                             : (nmi_prev & ~nmi_s); // see R25

  always_ff @(posedge mclk_i) begin
    if (rst_i || standby_i) begin
      nmi_prev <= 1'b1;
      nmi_pend <= 1'b0; // see R4
    end else begin
      nmi_prev <= nmi_s;
      if (nmi_edge) begin
        nmi_pend <= 1'b1;
      end else if (nmi_take) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // arbiter
  // ----------------------------------------------------------------
  logic [7:0]  ext_act;
  logic [32:0] per_act;
  logic        acc_valid;
  logic        acc_internal;
  logic [5:0]  acc_vec;
  logic        masked;

  assign masked  = flags[`IAE_MASK_BIT];
  assign ext_act = ~ext_s & ext_en_eff;           // see R1
  assign per_act = per_pend & {1'b1, per_en_eff}; // see R1, R2

  always_comb begin
    acc_valid    = 1'b0;
    acc_internal = 1'b0;
    acc_vec      = 6'h00;
    if (!masked) begin // see R3, R5
      for (int i = 32; i >= 0; i--) begin
        if (per_act[i]) begin
          acc_valid    = 1'b1;
          acc_internal = 1'b1;
          acc_vec      = `IAE_VEC_PER_BASE + 6'(i); // see R24
        end
      end
      for (int i = 7; i >= 0; i--) begin
        if (ext_act[i]) begin
          acc_valid    = 1'b1;
          acc_internal = 1'b0;
          acc_vec      = `IAE_VEC_EXT_BASE + 6'(i); // see R23, R6
        end
      end
    end
    if (nmi_pend) begin
      acc_valid    = 1'b1;
      acc_internal = 1'b0;
      acc_vec      = `IAE_VEC_NMI; // see R22, R4
    end
  end

  // ----------------------------------------------------------------
  // entry sequencer
  // ----------------------------------------------------------------
  logic [5:0]  cnt;
  logic [5:0]  word_states;
  logic [1:0]  words;
  logic [15:0] pc_lat;
  logic [15:0] sp_lat;
  logic [15:0] new_pc;

  // external words go out as two byte cycles, each stretched by the wait count
  assign word_states = ctrl[`IAE_CTRL_EXTMEM_BIT]
                     ? (`IAE_EXT_WORD_STATES + {1'b0, ctrl[7:`IAE_CTRL_WS_LSB], 1'b0}) // see R16
                     : `IAE_CHIP_WORD_STATES;
  assign nmi_take = (state == IAE_WAIT_END) && instr_end_i && nmi_pend;
  assign set_mask = (state == IAE_PUSH_FLAGS) && (cnt == 6'h00);

  always_ff @(posedge mclk_i) begin
    if (rst_i || standby_i) begin
      state        <= IAE_IDLE;
      cnt          <= 6'h00;
      words        <= 2'h0;
      vec_lat      <= 6'h00;
      pc_lat       <= 16'h0000;
      sp_lat       <= 16'h0000;
      new_pc       <= 16'h0000;
      mem_o        <= '0;
      int_req_o    <= 1'b0;
      vector_o     <= 6'h00;
      entry_busy_o <= 1'b0;
      branch_o     <= 1'b0;
      branch_pc_o  <= 16'h0000;
      sp_o         <= 16'h0000;
    end else begin
      branch_o <= 1'b0;
      case (state)
        IAE_IDLE: begin
          if (acc_valid) begin
            cnt   <= (acc_internal ? `IAE_PRIO_INT_STATES : `IAE_PRIO_EXT_STATES)
                     - 6'h01; // see R13
            state <= IAE_PRIO;
          end
        end
        IAE_PRIO: begin
          if (cnt == 6'h00) begin
            int_req_o <= acc_valid;
            vector_o  <= acc_vec;
            state     <= acc_valid ? IAE_WAIT_END : IAE_IDLE;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        IAE_WAIT_END: begin
          int_req_o <= acc_valid;
          vector_o  <= acc_vec;
          if (!acc_valid) begin
            state <= IAE_IDLE;
          end else if (instr_end_i) begin // see R7, R14, R18
            int_req_o    <= 1'b0;
            vec_lat      <= acc_vec;
            pc_lat       <= pc_i;
            sp_lat       <= {sp_i[15:1], 1'b0};
            entry_busy_o <= 1'b1;
            cnt          <= word_states - 6'h01;
            mem_o        <= '{req: 1'b1, we: 1'b1,
                              addr: {sp_i[15:1] - 15'h0001, 1'b0}, wdata: pc_i}; // see R8, R21
            state        <= IAE_PUSH_PC;
          end
        end
        IAE_PUSH_PC: begin
          if (cnt == 6'h00) begin
            cnt   <= word_states - 6'h01;
            mem_o <= '{req: 1'b1, we: 1'b1, addr: {sp_lat[15:1] - 15'h0002, 1'b0},
                       wdata: {flags, flags}}; // see R8, R11, R21
            state <= IAE_PUSH_FLAGS;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        IAE_PUSH_FLAGS: begin
          if (cnt == 6'h00) begin
            cnt   <= word_states - 6'h01;
            mem_o <= '{req: 1'b1, we: 1'b0, addr: {9'h000, vec_lat, 1'b0},
                       wdata: 16'h0000}; // see R26
            state <= IAE_VECTOR;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        IAE_VECTOR: begin
          if (cnt == 6'h00) begin
            new_pc <= mem_rdata_i; // see R10
            cnt    <= word_states - 6'h01;
            words  <= `IAE_FETCH_WORDS - 2'h1;
            mem_o  <= '{req: 1'b1, we: 1'b0, addr: {mem_rdata_i[15:1], 1'b0}, wdata: 16'h0000};
            state  <= IAE_FETCH;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        IAE_FETCH: begin
          if (cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
          end else if (words != 2'h0) begin
            words      <= words - 2'h1;
            cnt        <= word_states - 6'h01;
            mem_o.addr <= {mem_o.addr[15:1] + 15'h0001, 1'b0}; // see R15, R21
          end else begin
            mem_o <= '0;
            cnt   <= `IAE_INTERNAL_STATES - 6'h01; // see R15
            state <= IAE_INTERNAL;
          end
        end
        IAE_INTERNAL: begin
          if (cnt == 6'h00) begin
            branch_o     <= 1'b1;
            branch_pc_o  <= new_pc;
            sp_o         <= {sp_lat[15:1] - 15'h0002, 1'b0};
            entry_busy_o <= 1'b0;
            state        <= IAE_IDLE;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        default: begin
          state <= IAE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // condition flags byte
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flags <= `IAE_FLAGS_RST;
    end else begin
      if (return_from_exception_op_i) begin
        flags <= ret_word_i[15:8]; // see R12
      end else if (wr_strobe && wb_adr_i == `IAE_OFS_FLAGS && wb_sel_i[0]) begin
        flags <= wb_dat_i[7:0];
      end
      if (set_mask) begin
        flags[`IAE_MASK_BIT] <= 1'b1; // see R9
      end
    end
  end

  assign condition_flags_byte_o = flags;

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          `IAE_OFS_CTRL:     wb_dat_o <= {24'h0, ctrl};
          `IAE_OFS_EXT_EN:   wb_dat_o <= {24'h0, ext_en_sw};
          `IAE_OFS_PER_EN:   wb_dat_o <= per_en_sw;
          `IAE_OFS_FLAGS:    wb_dat_o <= {24'h0, flags};
          `IAE_OFS_STATUS:   wb_dat_o <= {16'h0, per_pend[32], nmi_pend, int_req_o,
                                          entry_busy_o, 1'b0, 3'(state), 2'h0, vec_lat};
          `IAE_OFS_EXT_PEND: wb_dat_o <= {24'h0, ext_act};
          `IAE_OFS_PER_PEND: wb_dat_o <= per_pend[31:0];
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/iae_interrupt_arbiter_and_entry_chk.sv
// port checker for the interrupt arbiter and entry sequencer
`timescale 1ns/100ps
`default_nettype none
module iae_interrupt_arbiter_and_entry_chk
  import iae_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire iae_mem_t    mem_o,
  input wire logic        int_req_o,
  input wire logic [5:0]  vector_o,
  input wire logic [7:0]  condition_flags_byte_o,
  input wire logic        entry_busy_o,
  input wire logic        branch_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_reset_masked: assert property ($fell(rst_i) |-> condition_flags_byte_o == 8'h80)
    else $error("flags not masked after reset");
  a_vector_range: assert property (int_req_o |-> vector_o inside {[6'h03:6'h2c]})
    else $error("vector out of range");
  a_mem_in_entry: assert property (mem_o.req |-> entry_busy_o)
    else $error("memory step outside entry");
  a_word_even: assert property (mem_o.req |-> !mem_o.addr[0])
    else $error("odd word address");
  a_mask_on_branch: assert property (branch_o |-> condition_flags_byte_o[7])
    else $error("mask clear at branch");
  a_branch_pulse: assert property (branch_o |=> !branch_o)
    else $error("branch longer than one cycle");
  a_entry_ends: assert property ($rose(entry_busy_o) |-> ##[1:300] branch_o)
    else $error("entry never branched");
  cover property (branch_o);
  cover property (int_req_o && vector_o == 6'h03);
  cover property (wb_ack_o);
endmodule

bind iae_interrupt_arbiter_and_entry iae_interrupt_arbiter_and_entry_chk u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .int_req_o(int_req_o),
  .vector_o(vector_o), .condition_flags_byte_o(condition_flags_byte_o),
  .entry_busy_o(entry_busy_o), .branch_o(branch_o));
`default_nettype wire

//--- tb/iae_core_model.sv
// behavioural processor core with word memory holding stack and vector table
`timescale 1ns/100ps
`default_nettype none
module iae_core_model
  import iae_pkg::*;
#(
  parameter int GAP = 5
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire iae_mem_t    mem_i,
  input  wire logic        busy_i,
  output logic             instr_end_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      sp_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  int          cnt = 0;
  // table entry v holds handler 16'h4000 + v
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h4000 + 16'(i);
  assign pc_o = 16'h0246;
  // odd on purpose, the block must force it even
  assign sp_o = 16'h0101;
  assign instr_end_o = (cnt == GAP - 1) && !busy_i;
  // released data bus shows the inverse of its last value
  assign rdata_o = (mem_i.req && !mem_i.we) ? mem[mem_i.addr[8:1]] : ~last;
  always @(posedge mclk_i) begin
    cnt <= (rst_i || cnt == GAP - 1) ? 0 : cnt + 1;
    last <= rdata_o;
    if (mem_i.req && mem_i.we) begin
      mem[mem_i.addr[8:1]] <= mem_i.wdata;
    end
  end
endmodule
`default_nettype wire

//--- tb/iae_interrupt_arbiter_and_entry_test.sv
// self-checking bench for the interrupt arbiter and entry sequencer
`timescale 1ns/100ps
`default_nettype none
`include "iae_cfg.svh"
module iae_interrupt_arbiter_and_entry_test
  import iae_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        standby = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        nonmask_n = 1'b1;
  logic [7:0]  ext_n = 8'hff;
  logic [32:0] preq = '0;
  logic        ret_op = 1'b0;
  logic [15:0] ret_word = 16'h0;
  logic [31:0] rdat, q;
  logic        ack, instr_end, int_req, busy, branch;
  logic [15:0] pc, sp, rdata, bpc, sp_new;
  logic [5:0]  vec;
  logic [7:0]  flags;
  iae_mem_t    mem_bus;
  int          n_errors = 0;
  int          num_checks = 0;

  always #5 mclk_i = ~mclk_i;

  iae_interrupt_arbiter_and_entry u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .standby_i(standby), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .nonmask_n_i(nonmask_n), .ext_req_n_i(ext_n), .periph_req_i(preq),
    .instr_end_i(instr_end), .pc_i(pc), .sp_i(sp), .return_from_exception_op_i(ret_op),
    .ret_word_i(ret_word), .mem_rdata_i(rdata), .mem_o(mem_bus), .int_req_o(int_req),
    .vector_o(vec),
    .condition_flags_byte_o(flags), .entry_busy_o(busy), .branch_o(branch),
    .branch_pc_o(bpc), .sp_o(sp_new));

  iae_core_model u_core (
    .mclk_i(mclk_i), .rst_i(rst_i), .mem_i(mem_bus), .busy_i(busy),
    .instr_end_o(instr_end), .pc_o(pc), .sp_o(sp), .rdata_o(rdata));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    chk("bus ack", 32'h1, 32'(ack));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("register read", e, q);
  endtask

  task automatic unmask(input logic [15:0] w);
    repeat (4) @(posedge mclk_i);
    ret_op <= 1'b1;
    ret_word <= w;
    @(posedge mclk_i);
    ret_op <= 1'b0;
    @(posedge mclk_i);
    chk("restored flags", 32'(w[15:8]), 32'(flags));
  endtask

  task automatic idle_chk();
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge mclk_i);
      seen = seen | int_req;
    end
    chk("int_req held low", 32'h0, 32'(seen));
  endtask

  task automatic entry(input logic [5:0] v, input logic [7:0] f, input int w);
    int n;
    int busy_n;
    logic [15:0] got;
    n = 0; busy_n = 0; got = 16'h0;
    u_core.mem[126] = 16'h0bad;
    u_core.mem[127] = 16'h0bad;
    while (int_req !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    chk("vector", 32'(v), 32'(vec));
    n = 0;
    while (branch !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      n++;
      if (busy === 1'b1) busy_n++;
      if (branch === 1'b1) got = bpc;
    end
    chk("busy states", 32'(5 * w + 4), 32'(busy_n));
    chk("handler", 32'(16'h4000 + 16'(v)), 32'(got));
    chk("stacked pc", 32'(pc), 32'(u_core.mem[127]));
    chk("stacked flags", 32'({f, f}), 32'(u_core.mem[126]));
    chk("mask set", 32'h1, 32'(flags[7]));
    chk("new sp", 32'h00fc, 32'(sp_new));
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(`IAE_OFS_CTRL, 32'h0);
    rd(`IAE_OFS_FLAGS, 32'h80);
    rd(`IAE_OFS_EXT_EN, 32'h0);
    rd(8'h1c, 32'h0);
    xfer(1'b1, `IAE_OFS_EXT_EN, 32'h9);
    rd(`IAE_OFS_EXT_EN, 32'h9);
    xfer(1'b1, `IAE_OFS_PER_EN, 32'h20);
    ext_n <= 8'hf6;
    idle_chk();
    unmask(16'h0055);
    entry(6'h04, 8'h00, 2);
    ext_n <= 8'hfd;
    unmask(16'h0055);
    idle_chk();
    ext_n <= 8'hff;
    preq[5] <= 1'b1;
    entry(6'h11, 8'h00, 2);
    preq <= 33'h1_0000_0000;
    repeat (8) @(posedge mclk_i);
    unmask(16'h0055);
    entry(6'h2c, 8'h00, 2);
    preq <= '0;
    xfer(1'b1, `IAE_OFS_CTRL, 32'h12);
    nonmask_n <= 1'b0;
    entry(6'h03, 8'h80, 8);
    nonmask_n <= 1'b1;
    idle_chk();
    xfer(1'b1, `IAE_OFS_CTRL, 32'h1);
    nonmask_n <= 1'b0;
    idle_chk();
    nonmask_n <= 1'b1;
    entry(6'h03, 8'h80, 2);
    ext_n <= 8'hfe;
    repeat (4) @(posedge mclk_i);
    rd(`IAE_OFS_EXT_PEND, 32'h1);
    // align to an instruction end so the deferred clear lands five cycles later
    do begin
      @(posedge mclk_i);
    end while (instr_end !== 1'b1);
    xfer(1'b1, `IAE_OFS_EXT_EN, 32'h0);
    rd(`IAE_OFS_EXT_PEND, 32'h1);
    rd(`IAE_OFS_EXT_PEND, 32'h0);
    rd(`IAE_OFS_EXT_EN, 32'h0);
    standby <= 1'b1;
    nonmask_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    nonmask_n <= 1'b1;
    idle_chk();
    standby <= 1'b0;
    idle_chk();
    final_report();
  end

  initial begin
    #50000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
